// *** hw/bmsf_top.sv ***
// Bus-matching synchronous FIFO with mailboxes, retransmit and programmable flags.
`timescale 1ns/10ps
//
// Contract
// - Store 36-bit words, depth by parameter, one way.
// - Read 36, 18 or 9 bits, either endian.
// - Writes and standard-mode reads transfer on rising edge only when enabled.
// - Simultaneous write and read handled on one edge.
// - Two mailboxes bypass memory, masked to bus width.
// - Each mailbox raises its own new-mail flag.
// - Full reset zeroes pointers, picks offset method.
// - Partial reset zeroes pointers, keeps configuration.
// - Rewind request restores read pointer in four cycles.
// - Standard mode needs a read for first word.
// - Fall-through shows first word without read.
// - Timing mode taken from select at reset.
// - Select gives endian during reset, mode after.
// - Standard mode flags mean empty and full.
// - Fall-through flags mean space and output valid.
// - Programmable almost-empty and almost-full flags exist.
// - Almost-empty low when count at most offset.
// - Almost-full low when free at most offset.
// - Status flags pass two synchronizer stages.
// - Offsets load parallel on data or serially.
// - Three select inputs pick five default offsets.
// - Parity option skips data bit eight in offsets.
// - Fall-through handshake allows chaining without glue.
// - Idle indication drops on the edge after activity starts.
module bmsf_top
#(
  parameter int DEPTH = bmsf_pkg::DEPTH_2K
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic partial_reset,
  input wire logic endian_timing_sel,
  input wire logic [1:0] bus_size,
  input wire logic default_offset_sel0,
  input wire logic default_offset_sel1,
  input wire logic default_offset_sel2,
  input wire logic parity_select,
  input wire logic serial_offset_in,
  input wire logic write_enable,
  input wire logic write_mail_sel,
  input wire logic [bmsf_pkg::WORD_W-1:0] write_data,
  input wire logic read_enable,
  input wire logic read_mail_sel,
  input wire logic rewind_request_n,
  input wire logic rewind_enable,
  input wire logic mail2_write,
  input wire logic [bmsf_pkg::WORD_W-1:0] mail2_wdata,
  input wire logic mail2_read,
  output logic [bmsf_pkg::WORD_W-1:0] read_data,
  output logic [bmsf_pkg::WORD_W-1:0] mail1_rdata,
  output logic [bmsf_pkg::WORD_W-1:0] mail2_rdata,
  output logic mail1_full,
  output logic mail2_full,
  output logic full_space_flag,
  output logic empty_valid_flag,
  output logic almost_empty,
  output logic almost_full,
  output logic fall_through_mode,
  output logic config_done,
  output logic power_down
);
  import bmsf_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_V = (AW + 1)'(DEPTH);
  localparam logic [AW:0] SER_LAST = (AW + 1)'(2 * AW - 1);

  logic [WORD_W-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic [AW-1:0] ae_off;
  logic [AW-1:0] af_off;
  logic [AW:0] ser_cnt;
  logic [1:0] piece;
  logic [1:0] size_q;
  logic big_endian;
  logic parity_q;
  logic serial_q;
  logic out_valid;
  logic rewinding;
  logic [2:0] rewind_cnt;
  logic srst_q;
  logic [WORD_W-1:0] mail1;
  logic [WORD_W-1:0] mail2;
  bmsf_cfg_t cfg_state;

  function automatic int piece_w(input logic [1:0] sz);
    case (sz)
      BUS_18: piece_w = PIECE18_W;
      BUS_9: piece_w = PIECE9_W;
      default: piece_w = WORD_W;
    endcase
  endfunction

  function automatic logic [1:0] last_idx(input logic [1:0] sz);
    case (sz)
      BUS_18: last_idx = LAST_18;
      BUS_9: last_idx = LAST_9;
      default: last_idx = LAST_36;
    endcase
  endfunction

  function automatic logic [WORD_W-1:0] width_mask(input logic [1:0] sz);
    width_mask = {WORD_W{1'b1}} >> (WORD_W - piece_w(sz));
  endfunction

  // Big-endian hands out the most significant piece first.
  function automatic logic [WORD_W-1:0] get_piece(input logic [WORD_W-1:0] w, input logic [1:0] sz,
                                                  input logic [1:0] idx, input logic be);
    logic [1:0] k;
    k = be ? 2'(last_idx(sz) - idx) : idx;
    get_piece = (w >> (piece_w(sz) * int'(k))) & width_mask(sz);
  endfunction

  function automatic logic [AW-1:0] def_off(input logic [2:0] fs);
    case (fs)
      FS_8: def_off = AW'(OFF_8);
      FS_16: def_off = AW'(OFF_16);
      FS_64: def_off = AW'(OFF_64);
      FS_256: def_off = AW'(OFF_256);
      FS_1024: def_off = AW'(OFF_1024);
      default: def_off = AW'(OFF_8);
    endcase
  endfunction

  // With parity interspersed, data bit eight carries no offset information.
  function automatic logic [AW-1:0] off_from_data(input logic [WORD_W-1:0] d, input logic par);
    if (par)
      off_from_data = AW'({d[WORD_W-1:PARITY_BIT+1], d[PARITY_BIT-1:0]});
    else
      off_from_data = d[AW-1:0];
  endfunction

  wire [2:0] fs_now = {default_offset_sel2, default_offset_sel1, default_offset_sel0};
  wire fs_prog = fs_now >= FS_SERIAL;
  wire [AW:0] count = wptr - rptr;
  wire [AW:0] free_cnt = DEPTH_V - count;
  wire full = count == DEPTH_V;
  wire avail = count != '0;
  wire last_piece = piece == last_idx(size_q);
  wire [WORD_W-1:0] cur_piece = get_piece(mem[rptr[AW-1:0]], size_q, piece, big_endian);
  wire running = cfg_state == BMSF_RUN && !partial_reset && !rewinding;
  wire do_write = write_enable && !write_mail_sel && !full && running;
  wire cfg_write = write_enable && !write_mail_sel && cfg_state != BMSF_RUN;
  wire take = fall_through_mode ? (!out_valid || read_enable) : read_enable;
  wire do_read = running && avail && !read_mail_sel && take;
  wire fall_through_mode_drain = running && fall_through_mode && take && !avail && !read_mail_sel;
  wire rewind_start = !rewind_request_n && rewind_enable && !rewinding && cfg_state == BMSF_RUN;
  wire rewind_end = rewinding && rewind_cnt == REWIND_LAST;
  wire mail1_set = write_enable && write_mail_sel;
  wire mail1_clr = read_enable && read_mail_sel && mail1_full;
  wire mail2_clr = mail2_read && mail2_full;
  wire next_mail1_full = mail1_set || (mail1_full && !mail1_clr);
  wire next_mail2_full = mail2_write || (mail2_full && !mail2_clr);
  wire raw_data_flag = fall_through_mode ? out_valid : avail;
  wire raw_space_flag = !full;
  wire raw_almost_empty = !(count <= {1'b0, ae_off});
  wire raw_almost_full = !(free_cnt <= {1'b0, af_off});
  wire busy = write_enable || read_enable || mail2_write || mail2_read || rewinding || !rewind_request_n;

  // Memory write port; a read of the same slot on the same edge sees old data safely.
  always_ff @(posedge clk)
  begin
    if (do_write)
      mem[wptr[AW-1:0]] <= write_data;
  end

  // Pointers; both resets flush, and the rewind rewinds only the read side.
  always_ff @(posedge clk)
  begin
    if (srst || partial_reset)
    begin
      wptr <= '0;
      rptr <= '0;
      piece <= '0;
    end
    else
    begin
      if (do_write)
        wptr <= wptr + 1'b1;
      if (rewind_end)
      begin
        rptr <= '0;
        piece <= '0;
      end
      else if (do_read)
      begin
        piece <= last_piece ? '0 : 2'(piece + 1'b1);
        if (last_piece)
          rptr <= rptr + 1'b1;
      end
    end
  end

  // Standard mode waits for a read; fall-through preloads the head piece.
  always_ff @(posedge clk)
  begin
    if (srst || partial_reset || rewind_end)
    begin
      read_data <= '0;
      out_valid <= 1'b0;
    end
    else if (do_read)
    begin
      read_data <= cur_piece;
      out_valid <= 1'b1;
    end
    else if (fall_through_mode_drain)
      out_valid <= 1'b0;
  end

  // Retransmit sequencer, four cycles from request to rewound pointer.
  always_ff @(posedge clk)
  begin
    if (srst || partial_reset)
    begin
      rewinding <= 1'b0;
      rewind_cnt <= '0;
    end
    else if (rewind_start)
    begin
      rewinding <= 1'b1;
      rewind_cnt <= '0;
    end
    else if (rewinding)
    begin
      rewinding <= !rewind_end;
      rewind_cnt <= 3'(rewind_cnt + 1'b1);
    end
  end

  // Configuration captured during full reset; partial reset leaves it alone.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      big_endian <= endian_timing_sel;
      size_q <= bus_size;
      parity_q <= parity_select;
      serial_q <= fs_now == FS_SERIAL;
    end
  end

  // Timing mode is latched on the edge that ends full reset, then held.
  always_ff @(posedge clk)
  begin
    srst_q <= srst;
    if (srst)
      fall_through_mode <= 1'b0;
    else if (srst_q)
      fall_through_mode <= !endian_timing_sel;
  end

  // Offsets: defaults at reset, then parallel words or a serial bit stream.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ae_off <= def_off(fs_now);
      af_off <= def_off(fs_now);
      ser_cnt <= '0;
      cfg_state <= fs_prog ? BMSF_LOAD_AE : BMSF_RUN;
    end
    else if (cfg_write && serial_q)
    begin
      {ae_off, af_off} <= {ae_off[AW-2:0], af_off, serial_offset_in};
      ser_cnt <= ser_cnt + 1'b1;
      if (ser_cnt == SER_LAST)
        cfg_state <= BMSF_RUN;
    end
    else if (cfg_write)
    begin
      case (cfg_state)
        BMSF_LOAD_AE:
        begin
          ae_off <= off_from_data(write_data, parity_q);
          cfg_state <= BMSF_LOAD_AF;
        end
        BMSF_LOAD_AF:
        begin
          af_off <= off_from_data(write_data, parity_q);
          cfg_state <= BMSF_RUN;
        end
        default: cfg_state <= BMSF_RUN;
      endcase
    end
  end

  // Mailboxes; a new write in the cycle of a read keeps the flag set.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mail1 <= '0;
      mail2 <= '0;
      mail1_rdata <= '0;
      mail2_rdata <= '0;
      mail1_full <= 1'b0;
      mail2_full <= 1'b0;
    end
    else
    begin
      if (mail1_set)
        mail1 <= write_data & width_mask(size_q);
      if (mail2_write)
        mail2 <= mail2_wdata & width_mask(size_q);
      if (mail1_clr)
        mail1_rdata <= mail1;
      if (mail2_clr)
        mail2_rdata <= mail2;
      mail1_full <= next_mail1_full;
      mail2_full <= next_mail2_full;
    end
  end

  // Idle status is a register, so it falls on the edge after activity starts.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      power_down <= 1'b0;
      config_done <= 1'b0;
    end
    else
    begin
      power_down <= !busy && !partial_reset;
      config_done <= cfg_state == BMSF_RUN;
    end
  end

  // Flags run through two stages, so they lag the true state by two edges;
  // the internal guards above never trust the delayed copies.
  bmsf_sync2 #(.RST_VAL(1'b0)) u_space_sync
  (
    .clk(clk),
    .srst(srst),
    .d(raw_space_flag),
    .q(full_space_flag)
  );

  bmsf_sync2 #(.RST_VAL(1'b0)) u_data_sync
  (
    .clk(clk),
    .srst(srst),
    .d(raw_data_flag),
    .q(empty_valid_flag)
  );

  // Almost-empty is low while the count is at or below its offset.
  bmsf_sync2 #(.RST_VAL(1'b0)) u_ae_sync
  (
    .clk(clk),
    .srst(srst),
    .d(raw_almost_empty),
    .q(almost_empty)
  );

  // Almost-full is low while free space is at or below its offset.
  bmsf_sync2 #(.RST_VAL(1'b1)) u_af_sync
  (
    .clk(clk),
    .srst(srst),
    .d(raw_almost_full),
    .q(almost_full)
  );

endmodule

// *** hw/bmsf_pkg.sv ***
// Shared constants and types for the bus-matching synchronous FIFO.
package bmsf_pkg;

  localparam int WORD_W = 36;
  localparam int PIECE18_W = 18;
  localparam int PIECE9_W = 9;
  localparam int DEPTH_2K = 2048;
  localparam int DEPTH_4K = 4096;
  localparam int DEPTH_8K = 8192;
  localparam int PARITY_BIT = 8;

  // Retransmit takes this many clock cycles.
  localparam int REWIND_CYCLES = 4;
  localparam logic [2:0] REWIND_LAST = 3'(REWIND_CYCLES - 1);

  // Read-port bus size codes.
  localparam logic [1:0] BUS_36 = 2'h0;
  localparam logic [1:0] BUS_18 = 2'h1;
  localparam logic [1:0] BUS_9 = 2'h2;
  localparam logic [1:0] LAST_36 = 2'h0;
  localparam logic [1:0] LAST_18 = 2'h1;
  localparam logic [1:0] LAST_9 = 2'h3;

  // Offset select codes sampled during full reset.
  localparam logic [2:0] FS_8 = 3'h0;
  localparam logic [2:0] FS_16 = 3'h1;
  localparam logic [2:0] FS_64 = 3'h2;
  localparam logic [2:0] FS_256 = 3'h3;
  localparam logic [2:0] FS_1024 = 3'h4;
  localparam logic [2:0] FS_SERIAL = 3'h5;
  localparam logic [2:0] FS_PARALLEL = 3'h6;

  localparam int OFF_8 = 8;
  localparam int OFF_16 = 16;
  localparam int OFF_64 = 64;
  localparam int OFF_256 = 256;
  localparam int OFF_1024 = 1024;

  // Offset programming progress after full reset.
  typedef enum logic [1:0] {
    BMSF_LOAD_AE = 2'b00,
    BMSF_LOAD_AF = 2'b01,
    BMSF_RUN = 2'b10
  } bmsf_cfg_t;

endpackage

// *** hw/bmsf_sync2.sv ***
// Two-stage flag synchronizer.
`timescale 1ns/10ps
module bmsf_sync2
#(
  parameter logic RST_VAL = 1'b0
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic d,
  output logic q
);

  logic stage1;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      stage1 <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule

// *** testbench/bmsf_top_sva.sv ***
// Port-level assertion checker for the bus-matching FIFO.
`timescale 1ns/10ps
module bmsf_checker
(
  input wire logic clk,
  input wire logic srst,
  input wire logic partial_reset,
  input wire logic write_enable,
  input wire logic write_mail_sel,
  input wire logic read_enable,
  input wire logic read_mail_sel,
  input wire logic rewind_request_n,
  input wire logic rewind_enable,
  input wire logic mail2_write,
  input wire logic mail2_read,
  input wire logic [bmsf_pkg::WORD_W-1:0] read_data,
  input wire logic mail1_full,
  input wire logic mail2_full,
  input wire logic full_space_flag,
  input wire logic empty_valid_flag,
  input wire logic almost_empty,
  input wire logic almost_full,
  input wire logic fall_through_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_reset_state: assert property (disable iff (1'b0) srst |=>
    !mail1_full && !mail2_full && !empty_valid_flag && !full_space_flag && almost_full && read_data == '0)
    else $error("reset state wrong");
  // Flags lag the flush by the two synchronizer stages plus the pointer register.
  a_flush_flags: assert property (partial_reset |-> ##3
    (!empty_valid_flag && !almost_empty && full_space_flag && almost_full)) else $error("flush flags wrong");
  a_empty_read: assert property (read_enable && !read_mail_sel && !empty_valid_flag && !fall_through_mode
    && !partial_reset && !write_enable && !$past(write_enable) && !$past(write_enable, 2)
    && !$past(write_enable, 3) |=> $stable(read_data)) else $error("read on empty changed data");
  // The pointer rewinds on the fourth blocked edge, so the cleared output shows one edge later.
  a_rewind_clear: assert property ($fell(rewind_request_n) && rewind_enable |-> ##5 (read_data == '0))
    else $error("rewind did not clear output");
  a_mail1_set: assert property (write_enable && write_mail_sel |=> mail1_full)
    else $error("mailbox one flag not set");
  a_mail1_clear: assert property (read_enable && read_mail_sel && mail1_full
    && !(write_enable && write_mail_sel) |=> !mail1_full) else $error("mailbox one flag not cleared");
  a_mail2_set: assert property (mail2_write |=> mail2_full)
    else $error("mailbox two flag not set");
  a_mail2_clear: assert property (mail2_read && mail2_full && !mail2_write |=> !mail2_full)
    else $error("mailbox two flag not cleared");
  a_mode_hold: assert property (!$past(srst) |=> $stable(fall_through_mode))
    else $error("timing mode changed");
  c_mail1: cover property (mail1_full && read_enable && read_mail_sel);
  c_rewind: cover property ($fell(rewind_request_n) && rewind_enable);
  c_full: cover property ($fell(full_space_flag));
endmodule
bind bmsf_top bmsf_checker u_chk (.clk, .srst, .partial_reset, .write_enable, .write_mail_sel, .read_enable,
  .read_mail_sel, .rewind_request_n, .rewind_enable, .mail2_write, .mail2_read, .read_data, .mail1_full,
  .mail2_full, .full_space_flag, .empty_valid_flag, .almost_empty, .almost_full, .fall_through_mode);

// *** testbench/bmsf_reader.sv ***
// Read-side consumer model that pulls a set number of reads, back to back or with gaps.
`timescale 1ns/10ps
module bmsf_reader
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [8:0] pull,
  input wire logic start,
  input wire logic slow,
  output logic read_enable,
  output logic busy,
  output logic taken
);
  logic [8:0] left = 9'h0;
  logic gap = 1'b0;
  assign busy = left != 9'h0;
  // Reads stop at the promised count; no flag is looked at, so a count above the stored words asks an empty store.
  assign read_enable = busy && !(slow && gap);
  always_ff @(posedge clk)
  begin
    gap <= !gap && !srst;
    // The piece taken on this edge stands on the outputs until the next edge.
    taken <= read_enable && !srst;
    if (srst)
      left <= 9'h0;
    else if (start)
      left <= pull;
    else if (read_enable)
      left <= left - 9'h1;
  end
endmodule

// *** testbench/test_bmsf_top.sv ***
// Self-checking bench for the bus-matching FIFO.
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("unexpected at %0t: mismatch", $time); end end
module test_bmsf_top;
  import bmsf_pkg::*;
  localparam int DEP = 64;
  logic clk = 0, srst = 1, partial_reset = 0, endian_timing_sel = 0, default_offset_sel0 = 0, write_enable = 0;
  logic write_mail_sel = 0, tb_re = 0, read_mail_sel = 0, rewind_request_n = 1, rewind_enable = 0;
  logic mail2_write = 0, mail2_read = 0, start = 0, slow = 0, be = 0;
  logic [1:0] sel_hi = 2'h0;
  logic [1:0] bus_size = BUS_36;
  logic [35:0] write_data = '0, mail2_wdata = '0, last, d;
  logic [8:0] pull = '0;
  logic [31:0] seed = 32'hcaa1;
  logic [35:0] q[$];
  logic [35:0] words[5];
  wire logic read_enable, pr_re, busy, taken, mail1_full, mail2_full, full_space_flag, empty_valid_flag;
  wire logic almost_empty, almost_full, fall_through_mode, config_done, power_down;
  wire logic [35:0] read_data, mail1_rdata, mail2_rdata;
  int errors = 0, comparisons = 0, n = 1, w = 36, stored = 0, off;
  int cnt[6];
  assign read_enable = pr_re | tb_re;
  always #5 clk = ~clk;
  bmsf_top #(.DEPTH(DEP)) DUT (.clk, .srst, .partial_reset, .endian_timing_sel, .bus_size, .default_offset_sel0,
    .default_offset_sel1(sel_hi[0]), .default_offset_sel2(sel_hi[1]), .parity_select(1'b0), .serial_offset_in(1'b0),
    .write_enable, .write_mail_sel, .write_data, .read_enable, .read_mail_sel, .rewind_request_n, .rewind_enable,
    .mail2_write, .mail2_wdata, .mail2_read, .read_data, .mail1_rdata, .mail2_rdata, .mail1_full, .mail2_full,
    .full_space_flag, .empty_valid_flag, .almost_empty, .almost_full, .fall_through_mode, .config_done,
    .power_down);
  bmsf_reader u_rd (.clk, .srst, .pull, .start, .slow, .read_enable(pr_re), .busy, .taken);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [35:0] mask();
    return (36'h1 << w) - 36'h1;
  endfunction
  task tick();
    @(posedge clk);
  endtask
  task note(input logic [35:0] x);
    for (int k = 0; k < n; k++)
      q.push_back((x >> (w * (be ? n - 1 - k : k))) & mask());
  endtask
  task wr(input int num);
    repeat (num)
    begin
      seed = lfsr(seed);
      last = {seed[3:0], seed};
      write_enable <= 1'b1;
      write_data <= last;
      if (stored < DEP)
        note(last);
      if (stored < 5)
        words[stored] = last;
      stored++;
      tick();
    end
    write_enable <= 1'b0;
  endtask
  task rd(input int num);
    pull <= 9'(num);
    start <= 1'b1;
    tick();
    start <= 1'b0;
    repeat (2) tick();
    for (int i = 0; i < 600 && busy; i++)
      tick();
    `CHK(busy, 1'b0)
    repeat (4) tick();
  endtask
  task flags(input logic ev, input logic ae, input logic af, input logic sp);
    @(negedge clk);
    `CHK(empty_valid_flag, ev)
    `CHK(almost_empty, ae)
    `CHK(almost_full, af)
    `CHK(full_space_flag, sp)
    `CHK(power_down, 1'b1)
    tick();
  endtask
  task cfg_reset(input logic [1:0] bs, input logic big, input logic code0, input logic mode);
    srst <= 1'b1;
    endian_timing_sel <= big;
    bus_size <= bs;
    default_offset_sel0 <= code0;
    repeat (2) tick();
    srst <= 1'b0;
    endian_timing_sel <= mode;
    stored = 0;
    repeat (3) tick();
  endtask
  task complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (taken && q.size() == 0)
    begin
      errors++;
      $display("unexpected at %0t: extra read", $time);
    end
    else if (taken)
      `CHK(read_data, q.pop_front())
  end
  initial
  begin
    repeat (20000) tick();
    errors++;
    $display("unexpected at %0t: timeout", $time);
    complete_run();
  end
  initial
  begin
    for (int c = 0; c < 3; c++)
    begin
      n = 1 << c;
      w = 36 / n;
      be = c == 1;
      slow = c == 1;
      off = c == 1 ? OFF_16 : OFF_8;
      cfg_reset(c == 0 ? BUS_36 : c == 1 ? BUS_18 : BUS_9, be, c == 1, 1'b1);
      tb_re <= 1'b1;
      tick();
      tb_re <= 1'b0;
      repeat (2) tick();
      @(negedge clk);
      `CHK(read_data, 36'h0)
      `CHK(fall_through_mode, 1'b0)
      `CHK(config_done, 1'b1)
      tick();
      cnt = '{off, 1, 62 - 2 * off, 1, off, 1};
      for (int s = 0; s < 6; s++)
      begin
        wr(cnt[s]);
        repeat (4) tick();
        flags(1'b1, s > 0, s < 3, s < 4);
      end
      rd(DEP * n);
      flags(1'b0, 1'b0, 1'b1, 1'b1);
      wr(3);
      partial_reset <= 1'b1;
      tick();
      partial_reset <= 1'b0;
      stored = 0;
      repeat (4) tick();
      flags(1'b0, 1'b0, 1'b1, 1'b1);
      wr(5);
      rd(5 * n);
      rewind_request_n <= 1'b0;
      rewind_enable <= 1'b1;
      tick();
      rewind_request_n <= 1'b1;
      rewind_enable <= 1'b0;
      repeat (6) tick();
      for (int k = 0; k < 5; k++)
        note(words[k]);
      rd(5 * n);
      seed = lfsr(seed);
      d = {seed[3:0], seed};
      write_enable <= 1'b1;
      write_mail_sel <= 1'b1;
      write_data <= d;
      mail2_write <= 1'b1;
      mail2_wdata <= ~d;
      tick();
      write_enable <= 1'b0;
      write_mail_sel <= 1'b0;
      mail2_write <= 1'b0;
      @(negedge clk);
      `CHK({mail1_full, mail2_full}, 2'h3)
      `CHK(power_down, 1'b0)
      tick();
      tb_re <= 1'b1;
      read_mail_sel <= 1'b1;
      mail2_read <= 1'b1;
      tick();
      tb_re <= 1'b0;
      read_mail_sel <= 1'b0;
      mail2_read <= 1'b0;
      @(negedge clk);
      `CHK(mail1_rdata, d & mask())
      `CHK(mail2_rdata, ~d & mask())
      `CHK({mail1_full, mail2_full}, 2'h0)
      tick();
    end
    n = 1;
    w = 36;
    // Parallel offsets of two words each make almost-empty rise at three stored words.
    sel_hi <= 2'h3;
    cfg_reset(BUS_36, 1'b0, 1'b0, 1'b1);
    sel_hi <= 2'h0;
    stored = DEP;
    `CHK(config_done, 1'b0)
    write_enable <= 1'b1;
    write_data <= 36'h2;
    repeat (2) tick();
    write_enable <= 1'b0;
    tick();
    wr(3);
    repeat (4) tick();
    `CHK(config_done, 1'b1)
    flags(1'b1, 1'b1, 1'b1, 1'b1);
    cfg_reset(BUS_36, 1'b0, 1'b0, 1'b0);
    stored = DEP;
    wr(1);
    repeat (6) tick();
    @(negedge clk);
    `CHK(fall_through_mode, 1'b1)
    `CHK(read_data, last)
    `CHK(empty_valid_flag, 1'b1)
    `CHK(q.size(), 0)
    complete_run();
  end
endmodule
